// >>> verilog/usw_defs.svh
// usw_defs.svh: offsets, field positions, reset values and timing for usw
// assumes a 25 MHz core clock and a 32-bit apb slave with word registers
`ifndef USW_DEFS_SVH
`define USW_DEFS_SVH

// register indices; byte address is four times the index
`define USW_IDX_USB_CONTROL_STATUS  20'hE680
`define USW_IDX_FORCED_LOW_POWER    20'hE681
`define USW_IDX_POWER_CONTROL       20'hE690
`define USW_IDX_WAKE_CONTROL        20'hE691
`define USW_IDX_EXT_INT_CONTROL     20'hE692
`define USW_IDX_IRQ_STATUS          20'hE693
`define USW_IDX_IRQ_MASK            20'hE694
`define USW_ADDR(idx)               ((idx) << 2)

// usb control/status fields
`define USW_UCS_RESUME_BIT          0
`define USW_UCS_RW_MASK             32'h0000000F
// power control fields
`define USW_PWR_IDLE_REQ_BIT        0
// wake control fields
`define USW_WK_PRI_EN_BIT           0
`define USW_WK_SEC_EN_BIT           1
`define USW_WK_BUS_EN_BIT           2
`define USW_WK_PRI_POL_BIT          4
`define USW_WK_SEC_POL_BIT          5
`define USW_WK_PRI_FLAG_BIT         6
`define USW_WK_SEC_FLAG_BIT         7
`define USW_WK_RESET                8'h05
// extended interrupt control fields
`define USW_EIC_WAKE_FLAG_BIT       4
`define USW_EIC_WAKE_EN_BIT         5
// interrupt status / mask fields
`define USW_IRQ_SUSPEND_BIT         0
`define USW_IRQ_WAKE_BIT            1

// timing
`define USW_CLK_KHZ                 25000
`define USW_SUSPEND_TIME_US         3000
`define USW_PLL_DELAY_TIME_US       200
`define USW_SUSPEND_CYCLES  ((`USW_SUSPEND_TIME_US * `USW_CLK_KHZ + 999) / 1000)
`define USW_PLL_CYCLES      ((`USW_PLL_DELAY_TIME_US * `USW_CLK_KHZ + 999) / 1000)

`endif

// >>> verilog/usw_pkg.sv
// usw_pkg: types shared by the suspend/wakeup control block
// assumes usw_defs.svh for all numeric constants
package usw_pkg;

  typedef logic [16:0] usw_count_t;

  typedef enum logic [1:0] {
    USW_RUN      = 2'h0,
    USW_IDLE     = 2'h1,
    USW_OSC_OFF  = 2'h3,
    USW_PLL_WAIT = 2'h2
  } usw_state_t;

  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] sync;
  } usw_sync_st_t;

  typedef struct packed {
    usw_count_t count;
    logic       hit;
  } usw_cnt_st_t;

  typedef struct packed {
    usw_state_t  state;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [3:0]  usb_cs;
    logic        idle_req;
    logic [7:0]  wake_ctrl;
    logic        wake_int_en;
    logic [1:0]  irq_status;
    logic [1:0]  irq_mask;
    logic        bus_susp;
    logic        forced_susp;
    logic        pri_act_prev;
    logic        sec_act_prev;
    logic        irq;
    logic        osc_enable;
    logic        clk_release;
    logic        cpu_run;
    logic        drive_k;
  } usw_top_st_t;

endpackage

// >>> verilog/usw_sync.sv
// usw_sync: two-flop synchroniser for asynchronous pin levels
// assumes inputs are static levels; first stage feeds only the second
`timescale 1ns/1ps
module usw_sync (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  input  wire logic [1:0] i_async,
  output logic [1:0]      o_sync
);
  usw_pkg::usw_sync_st_t q;
  usw_pkg::usw_sync_st_t next_q;

  always_comb begin
    next_q      = q;
    next_q.meta = i_async;
    next_q.sync = q.meta;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      q <= '1; // idle level of bus and pins, no false edge
    end else begin
      q <= next_q;
    end
  end

  assign o_sync = q.sync;
endmodule

// >>> verilog/usw_counter.sv
// usw_counter: saturating cycle counter with a one-cycle hit pulse
// assumes LIMIT fits in usw_count_t and is at least one
`timescale 1ns/1ps
module usw_counter #(
  parameter int unsigned LIMIT = 16
) (
  input  wire logic i_core_clk,
  input  wire logic i_rst,
  input  wire logic i_clear,
  input  wire logic i_run,
  output logic      o_hit
);
  localparam usw_pkg::usw_count_t LIM = usw_pkg::usw_count_t'(LIMIT);

  usw_pkg::usw_cnt_st_t q;
  usw_pkg::usw_cnt_st_t next_q;

  always_comb begin
    next_q     = q;
    next_q.hit = 1'b0;
    if (i_clear) begin
      next_q.count = '0;
    end else if (i_run && q.count != LIM) begin
      next_q.count = q.count + usw_pkg::usw_count_t'(1);
      next_q.hit   = (q.count == LIM - usw_pkg::usw_count_t'(1));
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign o_hit = q.hit;
endmodule

// >>> verilog/usw_suspend_wakeup_control.sv
// usw_suspend_wakeup_control: suspend detect, idle entry, oscillator stop and wakeup
// assumes an apb master on i_core_clk, async bus-idle and wake pins, always-on core clock
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`include "usw_defs.svh"

module usw_suspend_wakeup_control #(
  parameter int unsigned SUSPEND_CYCLES = `USW_SUSPEND_CYCLES,
  parameter int unsigned PLL_CYCLES     = `USW_PLL_CYCLES
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [19:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr,
  input  wire logic        i_bus_idle_j,
  input  wire logic        i_primary_wake_input,
  input  wire logic        i_secondary_wake_input,
  output logic             o_bus_drive_k,
  output logic             o_osc_enable,
  output logic             o_clk_release,
  output logic             o_cpu_run,
  output logic             o_irq
);
  usw_pkg::usw_top_st_t q;
  usw_pkg::usw_top_st_t next_q;

  logic [1:0] pins_sync;
  logic       unused_bus_bit;
  logic       bus_j_sync;
  logic       primary_sync;
  logic       secondary_sync;
  logic       susp_hit;
  logic       pll_hit;
  logic       pll_run;

  usw_sync u_sync_pins (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_async    ({i_secondary_wake_input, i_primary_wake_input}),
    .o_sync     (pins_sync)
  );

  usw_sync u_sync_bus (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_async    ({1'b0, i_bus_idle_j}),
    .o_sync     ({unused_bus_bit, bus_j_sync})
  );

  assign primary_sync   = pins_sync[0];
  assign secondary_sync = pins_sync[1];

  // 3 ms of J on the bus
  usw_counter #(
    .LIMIT (SUSPEND_CYCLES)
  ) u_suspend_timer (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_clear    (~bus_j_sync),
    .i_run      (bus_j_sync),
    .o_hit      (susp_hit)
  );

  assign pll_run = (q.state == usw_pkg::USW_PLL_WAIT);

  // pll restart delay
  usw_counter #(
    .LIMIT (PLL_CYCLES)
  ) u_pll_timer (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_clear    (~pll_run),
    .i_run      (pll_run),
    .o_hit      (pll_hit)
  );

  // apb decode
  logic        apb_setup;
  logic        apb_wr;
  logic        sel_ucs;
  logic        sel_forced;
  logic        sel_pwr;
  logic        sel_wake;
  logic        sel_eic;
  logic        sel_irq_st;
  logic        sel_irq_mk;
  logic        mapped;
  logic [31:0] rd_word;

  // wake sources
  logic       pri_act;
  logic       sec_act;
  logic       pri_en;
  logic       sec_en;
  logic       bus_en;
  logic       ev_pri;
  logic       ev_sec;
  logic       ev_bus;
  logic       wake_event;
  logic       src_active;
  logic       suspend_cond;
  logic       wake_exit;
  logic [1:0] irq_set;
  logic [1:0] irq_clr;
  logic [1:0] pin_set;
  logic [1:0] pin_clr;

  always_comb begin
    apb_setup  = i_psel & ~i_penable;
    apb_wr     = i_psel & i_penable & q.pready & i_pwrite;
    sel_ucs    = (i_paddr == `USW_ADDR(`USW_IDX_USB_CONTROL_STATUS));
    sel_forced = (i_paddr == `USW_ADDR(`USW_IDX_FORCED_LOW_POWER));
    sel_pwr    = (i_paddr == `USW_ADDR(`USW_IDX_POWER_CONTROL));
    sel_wake   = (i_paddr == `USW_ADDR(`USW_IDX_WAKE_CONTROL));
    sel_eic    = (i_paddr == `USW_ADDR(`USW_IDX_EXT_INT_CONTROL));
    sel_irq_st = (i_paddr == `USW_ADDR(`USW_IDX_IRQ_STATUS));
    sel_irq_mk = (i_paddr == `USW_ADDR(`USW_IDX_IRQ_MASK));
    mapped     = sel_ucs | sel_forced | sel_pwr | sel_wake | sel_eic | sel_irq_st
               | sel_irq_mk;
    rd_word    = 32'h00000000;
    if (sel_ucs) begin
      rd_word[3:0] = q.usb_cs;
    end
    if (sel_pwr) begin
      rd_word[`USW_PWR_IDLE_REQ_BIT] = q.idle_req;
    end
    if (sel_wake) begin
      rd_word[7:0] = q.wake_ctrl;
    end
    if (sel_eic) begin
      rd_word[`USW_EIC_WAKE_EN_BIT]   = q.wake_int_en;
      rd_word[`USW_EIC_WAKE_FLAG_BIT] = q.irq_status[`USW_IRQ_WAKE_BIT];
    end
    if (sel_irq_st) begin
      rd_word[1:0] = q.irq_status;
    end
    if (sel_irq_mk) begin
      rd_word[1:0] = q.irq_mask;
    end
  end

  always_comb begin
    pri_en  = q.wake_ctrl[`USW_WK_PRI_EN_BIT];
    sec_en  = q.wake_ctrl[`USW_WK_SEC_EN_BIT];
    bus_en  = q.wake_ctrl[`USW_WK_BUS_EN_BIT];
    // active level follows polarity bit
    pri_act = ~(primary_sync ^ q.wake_ctrl[`USW_WK_PRI_POL_BIT]);
    sec_act = ~(secondary_sync ^ q.wake_ctrl[`USW_WK_SEC_POL_BIT]);
    // enabled sources only
    ev_pri     = pri_act & ~q.pri_act_prev & pri_en;
    ev_sec     = sec_act & ~q.sec_act_prev & sec_en;
    ev_bus     = ~bus_j_sync & bus_en;
    wake_event = ev_pri | ev_sec | ev_bus;
    src_active = (pri_act & pri_en) | (sec_act & sec_en) | ev_bus;
    suspend_cond = q.bus_susp | q.forced_susp;
  end

  always_comb begin
    next_q           = q;
    wake_exit        = 1'b0;
    irq_set          = 2'b00;
    irq_clr          = 2'b00;
    pin_set          = 2'b00;
    pin_clr          = 2'b00;
    next_q.pready    = apb_setup;
    next_q.pslverr   = apb_setup & ~mapped;
    next_q.prdata    = apb_setup ? rd_word : 32'h00000000;
    next_q.pri_act_prev = pri_act;
    next_q.sec_act_prev = sec_act;

    // bus suspend detect
    if (susp_hit) begin
      next_q.bus_susp = 1'b1;
      irq_set[`USW_IRQ_SUSPEND_BIT] = 1'b1;
    end
    if (~bus_j_sync) begin
      next_q.bus_susp = 1'b0;
    end

    // pin flags latch the causing pin
    pin_set = {ev_sec, ev_pri};

    case (q.state)
      usw_pkg::USW_RUN: begin
        if (q.idle_req) begin
          next_q.state = usw_pkg::USW_IDLE;
        end
      end
      usw_pkg::USW_IDLE: begin
        // stop only with suspend and quiet sources
        if (q.wake_int_en && (!suspend_cond || wake_event)) begin
          wake_exit = 1'b1;
        end else if (suspend_cond && !src_active) begin
          next_q.state = usw_pkg::USW_OSC_OFF;
        end
      end
      usw_pkg::USW_OSC_OFF: begin
        // no exit without enabled wake interrupt
        if (wake_event && q.wake_int_en) begin
          next_q.state = usw_pkg::USW_PLL_WAIT;
        end
      end
      usw_pkg::USW_PLL_WAIT: begin
        if (pll_hit) begin
          wake_exit = 1'b1;
        end
      end
      default: begin
        next_q.state = usw_pkg::USW_RUN;
      end
    endcase

    // leave idle with wakeup interrupt
    if (wake_exit) begin
      next_q.state       = usw_pkg::USW_RUN;
      next_q.idle_req    = 1'b0;
      next_q.forced_susp = 1'b0;
      irq_set[`USW_IRQ_WAKE_BIT] = 1'b1;
    end

    if (apb_wr) begin
      if (sel_ucs) begin
        next_q.usb_cs = i_pwdata[3:0];
      end
      if (sel_forced) begin
        next_q.forced_susp = 1'b1;
      end
      if (sel_pwr) begin
        next_q.idle_req = i_pwdata[`USW_PWR_IDLE_REQ_BIT];
      end
      if (sel_wake) begin
        next_q.wake_ctrl[5:0] = {i_pwdata[5:4], 1'b0, i_pwdata[2:0]};
        pin_clr = {i_pwdata[`USW_WK_SEC_FLAG_BIT], i_pwdata[`USW_WK_PRI_FLAG_BIT]};
      end
      if (sel_eic) begin
        next_q.wake_int_en = i_pwdata[`USW_EIC_WAKE_EN_BIT];
        irq_clr[`USW_IRQ_WAKE_BIT] = i_pwdata[`USW_EIC_WAKE_FLAG_BIT];
      end
      if (sel_irq_st) begin
        irq_clr = irq_clr | i_pwdata[1:0];
      end
      if (sel_irq_mk) begin
        next_q.irq_mask = i_pwdata[1:0];
      end
    end

    // set wins over clear
    next_q.irq_status = (q.irq_status & ~irq_clr) | irq_set;
    next_q.wake_ctrl[7:6] = (q.wake_ctrl[7:6] & ~pin_clr) | pin_set;
    next_q.irq = |(next_q.irq_status & next_q.irq_mask);

    // clock and resume outputs
    next_q.osc_enable  = (next_q.state != usw_pkg::USW_OSC_OFF);
    next_q.clk_release = (next_q.state != usw_pkg::USW_OSC_OFF)
                       && (next_q.state != usw_pkg::USW_PLL_WAIT);
    next_q.cpu_run     = (next_q.state == usw_pkg::USW_RUN);
    next_q.drive_k     = next_q.usb_cs[`USW_UCS_RESUME_BIT];
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      q             <= '0;
      q.state       <= usw_pkg::USW_RUN;
      q.wake_ctrl   <= `USW_WK_RESET;
      q.osc_enable  <= 1'b1;
      q.clk_release <= 1'b1;
      q.cpu_run     <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign o_pready      = q.pready;
  assign o_prdata      = q.prdata;
  assign o_pslverr     = q.pslverr;
  assign o_bus_drive_k = q.drive_k;
  assign o_osc_enable  = q.osc_enable;
  assign o_clk_release = q.clk_release;
  assign o_cpu_run     = q.cpu_run;
  assign o_irq         = q.irq;
endmodule

// >>> testbench/usw_sva.sv
// usw_sva: port assertions for the suspend/wakeup control block
// assumes one core clock, synchronous active-high reset, bound to the top
`timescale 1ns/1ps
`include "usw_defs.svh"
module usw_sva #(
  parameter int unsigned SUSPEND_CYCLES = 20,
  parameter int unsigned PLL_CYCLES     = 8
) (
  input wire logic        i_core_clk,
  input wire logic        i_rst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [19:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic        o_pready,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pslverr,
  input wire logic        o_bus_drive_k,
  input wire logic        o_osc_enable,
  input wire logic        o_clk_release,
  input wire logic        o_cpu_run,
  input wire logic        o_irq
);
  localparam int          PLL_HI = PLL_CYCLES + 3;
  localparam logic [19:0] UCS    = `USW_ADDR(`USW_IDX_USB_CONTROL_STATUS);
  logic [16:0] pll_cnt;
  logic        ucs_wr;
  assign ucs_wr = i_psel && i_penable && i_pwrite && o_pready && i_paddr == UCS;
  // cycles spent with oscillator up but clock held back
  always_ff @(posedge i_core_clk) begin
    if (i_rst || o_clk_release || !o_osc_enable) begin
      pll_cnt <= 17'h00000;
    end else begin
      pll_cnt <= pll_cnt + 17'h00001;
    end
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  a_ready_after_setup: assert property (i_psel && !i_penable |=> o_pready)
    else $error("pready missing after setup");
  a_ready_single: assert property (o_pready |=> !o_pready)
    else $error("pready held too long");
  a_err_with_ready: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
  a_data_quiet: assert property (!o_pready |-> o_prdata == 32'h00000000)
    else $error("prdata not zero outside access");
  a_k_by_write: assert property ($changed(o_bus_drive_k) |-> $past(ucs_wr) ||
    $past(ucs_wr, 2) || $past(i_rst)) else $error("drive k moved without write");
  a_run_clocked: assert property (o_cpu_run |-> o_osc_enable && o_clk_release)
    else $error("cpu runs without clock");
  a_pll_delay: assert property ($rose(o_clk_release) |->
    pll_cnt >= PLL_CYCLES - 1 && pll_cnt <= PLL_CYCLES + 1) else $error("pll delay wrong");
  a_wake_resumes: assert property ($rose(o_osc_enable) |-> ##[1:PLL_HI] o_cpu_run)
    else $error("no resume after oscillator restart");
  a_stop_in_idle: assert property ($fell(o_osc_enable) |-> !o_cpu_run && !o_clk_release)
    else $error("oscillator stopped while running");
  a_reset_state: assert property ($past(i_rst) |-> o_osc_enable && o_cpu_run && !o_irq)
    else $error("bad state after reset");
  c_osc_stop: cover property ($fell(o_osc_enable));
  c_pll_done: cover property ($rose(o_clk_release));
  c_refused: cover property (o_pslverr);
  c_resume_k: cover property ($rose(o_bus_drive_k));
endmodule
bind usw_suspend_wakeup_control usw_sva #(.SUSPEND_CYCLES(SUSPEND_CYCLES),
  .PLL_CYCLES(PLL_CYCLES)) u_sva (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
  .o_bus_drive_k(o_bus_drive_k), .o_osc_enable(o_osc_enable),
  .o_clk_release(o_clk_release), .o_cpu_run(o_cpu_run), .o_irq(o_irq));

// >>> testbench/usw_host_model.sv
// usw_host_model: upstream host/hub seen as the bus idle level
// assumes bench requests host activity; bus rests in J when nobody drives
`timescale 1ns/1ps
module usw_host_model (
  input  wire logic i_core_clk,
  input  wire logic i_activity,
  input  wire logic i_device_k,
  output logic      o_bus_idle_j
);
  logic k_seen = 1'b0;
  initial o_bus_idle_j = 1'b1;
  // bus idles in J; host traffic or resume K leaves J
  always @(posedge i_core_clk) begin
    k_seen       <= i_device_k;
    o_bus_idle_j <= !(i_activity || k_seen);
  end
endmodule

// >>> testbench/tb_usb_suspend_wakeup_control.sv
// tb_usb_suspend_wakeup_control: self-checking bench for the suspend/wakeup block
// assumes apb master here, host model on the bus pin, wake pins driven here
`timescale 1ns/1ps
`include "usw_defs.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_usb_suspend_wakeup_control;
  localparam int          SC  = 20;
  localparam int          PC  = 8;
  localparam logic [19:0] UCS = `USW_ADDR(`USW_IDX_USB_CONTROL_STATUS);
  localparam logic [19:0] FRC = `USW_ADDR(`USW_IDX_FORCED_LOW_POWER);
  localparam logic [19:0] PWR = `USW_ADDR(`USW_IDX_POWER_CONTROL);
  localparam logic [19:0] WAK = `USW_ADDR(`USW_IDX_WAKE_CONTROL);
  localparam logic [19:0] EIC = `USW_ADDR(`USW_IDX_EXT_INT_CONTROL);
  localparam logic [19:0] IST = `USW_ADDR(`USW_IDX_IRQ_STATUS);
  localparam logic [19:0] IMK = `USW_ADDR(`USW_IDX_IRQ_MASK);
  typedef struct {logic w; logic [19:0] a; logic [31:0] d; logic e;} usw_note_t;
  usw_note_t   notes[$];
  usw_note_t   nt;
  int          errors = 0;
  int          check_count = 0;
  int          seed = 79;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, bus_j, pri, sec;
  logic        drive_k, osc, rel, run, irq, activity;
  logic [19:0] paddr;
  logic [31:0] pwdata, prdata, v;
  usw_suspend_wakeup_control #(.SUSPEND_CYCLES(SC), .PLL_CYCLES(PC)) uut (
    .i_core_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(pslverr), .i_bus_idle_j(bus_j), .i_primary_wake_input(pri),
    .i_secondary_wake_input(sec), .o_bus_drive_k(drive_k), .o_osc_enable(osc),
    .o_clk_release(rel), .o_cpu_run(run), .o_irq(irq));
  usw_host_model host (.i_core_clk(clk), .i_activity(activity), .i_device_k(drive_k),
    .o_bus_idle_j(bus_j));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic apb(input logic w, input logic [19:0] a, input logic [31:0] d,
                     input logic [31:0] x, input logic xe);
    notes.push_back('{w, a, x, xe});
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // result watcher: each answered transfer against its oldest note
  always @(posedge clk) begin
    if (pready === 1'b1 && notes.size() > 0) begin
      nt = notes.pop_front();
      if (!nt.w) `CHK($sformatf("reg %h", nt.a), nt.d, prdata)
      `CHK($sformatf("err %h", nt.a), nt.e, pslverr)
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    close_out();
  end
  initial begin
    {psel, penable, pwrite, activity} = 4'h0;
    paddr    = 20'h00000;
    pwdata   = 32'h00000000;
    {pri, sec} = 2'h3;
    rst      = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    apb(0, WAK, 0, 32'h05, 0);
    apb(0, EIC, 0, 32'h00, 0);
    apb(0, 20'h00000, 0, 0, 1);
    apb(1, 20'h00010, 32'hFF, 0, 1);
    apb(0, FRC, 0, 0, 0);
    $display("test reset_map done");
    activity <= 1'b1;
    repeat (3) @(posedge clk);
    activity <= 1'b0;
    apb(1, IST, 32'h03, 0, 0);
    apb(0, IST, 0, 32'h00, 0);
    repeat (SC + 5) @(posedge clk);
    apb(0, IST, 0, 32'h01, 0);
    `CHK("irq", 1'b0, irq)
    apb(1, IMK, 32'h03, 0, 0);
    `CHK("irq", 1'b1, irq)
    apb(1, IST, 32'h01, 0, 0);
    `CHK("irq", 1'b0, irq)
    $display("test suspend_irq done");
    // firmware resume pulses; drive_k follows written bit 0 without wake permission
    repeat (4) begin
      v = $random(seed);
      apb(1, UCS, v, 0, 0);
      `CHK("drive_k", v[0], drive_k)
      apb(0, UCS, 0, v & 32'h0000000F, 0);
    end
    apb(1, UCS, 0, 0, 0);
    $display("test resume done");
    apb(1, FRC, 32'h5A, 0, 0);
    apb(1, PWR, 32'h01, 0, 0);
    for (int n = 0; n < 300 && osc !== 1'b0; n++) @(posedge clk);
    pri <= 1'b0;
    repeat (PC + 10) @(posedge clk);
    `CHK("osc", 1'b0, osc)
    `CHK("run", 1'b0, run)
    pri <= 1'b1;
    do_reset();
    $display("test no_wake done");
    apb(1, EIC, 32'h20, 0, 0);
    pri <= 1'b0;
    apb(1, FRC, 32'h00, 0, 0);
    apb(1, PWR, 32'h01, 0, 0);
    repeat (10) @(posedge clk);
    `CHK("osc", 1'b1, osc)
    `CHK("run", 1'b0, run)
    pri <= 1'b1;
    for (int n = 0; n < 300 && osc !== 1'b0; n++) @(posedge clk);
    `CHK("osc", 1'b0, osc)
    pri <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK("osc", 1'b1, osc)
    `CHK("rel", 1'b0, rel)
    for (int n = 0; n < 300 && run !== 1'b1; n++) @(posedge clk);
    `CHK("run", 1'b1, run)
    apb(0, WAK, 0, 32'h45, 0);
    apb(1, WAK, 32'h45, 0, 0);
    apb(0, WAK, 0, 32'h05, 0);
    apb(0, IST, 0, 32'h03, 0);
    pri <= 1'b1;
    sec <= 1'b0;
    $display("test primary_wake done");
    apb(1, WAK, 32'hE6, 0, 0);
    apb(1, WAK, 32'hE6, 0, 0);
    apb(1, FRC, 32'h00, 0, 0);
    apb(1, PWR, 32'h01, 0, 0);
    for (int n = 0; n < 300 && osc !== 1'b0; n++) @(posedge clk);
    sec <= 1'b1;
    for (int n = 0; n < 300 && run !== 1'b1; n++) @(posedge clk);
    `CHK("run", 1'b1, run)
    apb(0, WAK, 0, 32'hA6, 0);
    sec <= 1'b0;
    apb(1, WAK, 32'hE6, 0, 0);
    $display("test secondary_wake done");
    apb(1, FRC, 32'h00, 0, 0);
    apb(1, PWR, 32'h01, 0, 0);
    for (int n = 0; n < 300 && osc !== 1'b0; n++) @(posedge clk);
    `CHK("osc", 1'b0, osc)
    activity <= 1'b1;
    repeat (3) @(posedge clk);
    activity <= 1'b0;
    for (int n = 0; n < 300 && run !== 1'b1; n++) @(posedge clk);
    `CHK("run", 1'b1, run)
    apb(0, WAK, 0, 32'h26, 0);
    $display("test bus_wake done");
    apb(1, WAK, 32'h00, 0, 0);
    activity <= 1'b1;
    apb(1, IST, 32'h03, 0, 0);
    apb(1, PWR, 32'h01, 0, 0);
    repeat (6) @(posedge clk);
    `CHK("run", 1'b1, run)
    `CHK("osc", 1'b1, osc)
    apb(0, IST, 0, 32'h02, 0);
    activity <= 1'b0;
    $display("test unsuspended_idle done");
    repeat (4) @(posedge clk);
    close_out();
  end
endmodule
